// >>> hdl/asat_dtype.sv
`timescale 1ns/1ps
module asat_dtype
  import asat_pkg::*;
(
  input  wire [31:0] operand,   // operand under test
  input  wire [4:0]  bf_pos,    // bit field start
  input  wire [5:0]  bf_len,    // bit field length
  input  wire        op32,      // operand is a dword
  output logic [31:0] bf_field, // extracted field, right aligned
  output logic        bf_err,   // field empty or too long
  output logic        bcd_ok,   // low byte is valid packed decimal
  output logic        negative, // sign of the operand
  output logic [31:0] sext      // operand sign extended to 32 bits
);

  logic [32:0] mask;
  logic [6:0]  span;

  // ****************************************************************
  // bit field, decimal and sign views
  // ****************************************************************
  // mask is one bit wider so a 32-bit field needs no special case
  assign mask     = (33'h0_0000_0001 << bf_len) - 33'h0_0000_0001;
  // seven bits so the largest position plus length cannot wrap below 32
  assign span     = 7'(bf_pos) + 7'(bf_len);
  assign bf_field = (operand >> bf_pos) & mask[31:0];
  assign bf_err   = (bf_len == 6'h00) | (span > {1'b0, ASAT_BF_MAX});
  assign bcd_ok   = (operand[3:0] <= ASAT_BCD_MAX)
                  & (operand[7:4] <= ASAT_BCD_MAX);
  assign negative = op32 ? operand[31] : operand[15];
  assign sext     = op32 ? operand : {{16{operand[15]}}, operand[15:0]};

endmodule

// >>> hdl/asat_ea_calc.sv
`timescale 1ns/1ps
module asat_ea_calc
  import asat_pkg::*;
(
  input  asat_ctrl_s  ctrl,       // addressing form and mode
  input  wire [31:0]  base_val,   // selected base register
  input  wire [31:0]  index_val,  // selected index register
  input  wire [31:0]  disp_raw,   // displacement as written
  output asat_ea_s    ea          // offset, sizes and errors
);

  logic        def32;
  logic        ad32;
  logic [31:0] base_op;
  logic [31:0] idx_op;
  logic [31:0] disp_op;
  logic [31:0] sum;
  logic        bad16;
  logic        bad32;

  // ****************************************************************
  // size selection and offset sum
  // ****************************************************************
  // real mode forces the 16-bit default whatever the flag says
  assign def32 = ~ctrl.real_mode & ctrl.def_size;
  assign ad32  = def32 ^ ctrl.ad_ovr;

  // 16-bit forms only see the low word of each register
  always_comb begin
    base_op = ctrl.base_en ? (ad32 ? base_val : {16'h0000, base_val[15:0]}) : 32'h0000_0000;
    idx_op  = ctrl.index_en ? (ad32 ? index_val : {16'h0000, index_val[15:0]}) : 32'h0000_0000;
    idx_op  = ad32 ? (idx_op << ctrl.scale) : idx_op;
    case (ctrl.disp_size)
      ASAT_DISP_NONE: disp_op = 32'h0000_0000;
      ASAT_DISP_BYTE: disp_op = {{24{disp_raw[7]}}, disp_raw[7:0]};
      ASAT_DISP_WIDE: disp_op = ad32 ? disp_raw : {{16{disp_raw[15]}}, disp_raw[15:0]};
      default:        disp_op = 32'h0000_0000;
    endcase
  end

  assign sum = base_op + idx_op + disp_op;

  // register and scale restrictions per address size
  assign bad16 = (ctrl.base_en & (ctrl.base_sel != ASAT_REG_B)
                  & (ctrl.base_sel != ASAT_REG_FRAME))
               | (ctrl.index_en & (ctrl.index_sel != ASAT_REG_SI)
                  & (ctrl.index_sel != ASAT_REG_DEST))
               | (ctrl.scale != 2'h0);
  assign bad32 = ctrl.index_en & (ctrl.index_sel == ASAT_REG_SP);

  assign ea.offset    = ad32 ? sum : {16'h0000, sum[15:0]};
  assign ea.form_err  = (ctrl.disp_size == 2'h3) | (ad32 ? bad32 : bad16);
  // in real mode the override widens the forms only, never the reach
  assign ea.range_err = ctrl.real_mode & (ea.offset > ASAT_REAL_LIMIT);
  assign ea.op32      = def32 ^ ctrl.op_ovr;
  assign ea.ad32      = ad32;

endmodule

// >>> hdl/asat_top.sv
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module asat_top
  import asat_pkg::*;
(
  input  wire         SYS_CLK,    // core clock, 20 MHz
  input  wire         RST,        // asynchronous reset, active high
  input  wire         PSEL,       // apb select
  input  wire         PENABLE,    // apb access phase
  input  wire         PWRITE,     // apb direction
  input  wire  [11:0] PADDR,      // apb byte address
  input  wire  [31:0] PWDATA,     // apb write data
  output logic [31:0] PRDATA,     // apb read data
  output logic        PREADY,     // apb ready
  output logic        PSLVERR,    // apb error, unmapped address
  output logic [31:0] PHYS_ADDR,  // physical address pins
  output logic        PHYS_VALID, // pulse, new physical address
  output logic        GP_FAULT    // pulse, protection fault
);

  // ****************************************************************
  // state
  // ****************************************************************
  asat_ctrl_s  ctrl_r;
  asat_state_e state_r;
  asat_ea_s    ea;
  logic [31:0] disp_r;
  logic [15:0] sel_r;
  logic [31:0] segbase_r;
  logic [31:0] frame_r;
  logic [31:0] offset_r;
  logic [31:0] linear_r;
  logic        op32_r;
  logic        ad32_r;
  logic        done_r;
  logic        fault_r;
  logic        form_err_r;
  logic [10:0] dtcfg_r;
  logic [31:0] dtopnd_r;
  logic [31:0] gpr_r [8];
  logic [7:0]  mem_r [ASAT_MEM_BYTES];
  logic [31:0] bf_field;
  logic        bf_err;
  logic        bcd_ok;
  logic        negative;
  logic [31:0] sext;
  logic [31:0] linear_nxt;
  logic [31:0] phys_nxt;
  logic        acc;
  logic        wr;
  logic        go;
  logic        store;

  // apb write takes effect at the edge that sees pready high
  assign acc   = PSEL & PENABLE & PREADY;
  assign wr    = acc & PWRITE;
  assign go    = wr & (PADDR == ASAT_GO_OFS) & (state_r == ASAT_IDLE);
  assign store = wr & (PADDR == ASAT_STORE_OFS) & (state_r == ASAT_IDLE);

  // ****************************************************************
  // address decode helpers
  // ****************************************************************
  function automatic logic is_mem(input logic [11:0] a);
    is_mem = (a[11:4] == ASAT_MEM_OFS[11:4]) & (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_gpr(input logic [11:0] a);
    is_gpr = (a[11:5] == ASAT_GPR_OFS[11:5]) & (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = ((a <= ASAT_PTR_OFS) & (a[1:0] == 2'b00)) | is_mem(a) | is_gpr(a);
  endfunction

  // ****************************************************************
  // datapath instances
  // ****************************************************************
  asat_ea_calc u_ea (
    .ctrl      (ctrl_r),
    .base_val  (gpr_r[ctrl_r.base_sel]),
    .index_val (gpr_r[ctrl_r.index_sel]),
    .disp_raw  (disp_r),
    .ea        (ea)
  );

  asat_dtype u_dt (
    .operand  (dtopnd_r),
    .bf_pos   (dtcfg_r[4:0]),
    .bf_len   (dtcfg_r[10:5]),
    .op32     (op32_r),
    .bf_field (bf_field),
    .bf_err   (bf_err),
    .bcd_ok   (bcd_ok),
    .negative (negative),
    .sext     (sext)
  );

  // ****************************************************************
  // software registers
  // ****************************************************************
  // reserved control bits are dropped on write and read as zero
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ctrl_r    <= asat_ctrl_s'(ASAT_CTRL_RST);
      disp_r    <= ASAT_ZERO_RST;
      sel_r     <= ASAT_ZERO_RST[15:0];
      segbase_r <= ASAT_ZERO_RST;
      frame_r   <= ASAT_ZERO_RST;
      dtcfg_r   <= ASAT_ZERO_RST[10:0];
      dtopnd_r  <= ASAT_ZERO_RST;
    end else if (wr) begin
      case (PADDR)
        ASAT_CTRL_OFS:    ctrl_r    <= asat_ctrl_s'({15'h0000, PWDATA[16:0]});
        ASAT_DISP_OFS:    disp_r    <= PWDATA;
        ASAT_SEL_OFS:     sel_r     <= PWDATA[15:0];
        ASAT_SEGBASE_OFS: segbase_r <= PWDATA;
        ASAT_FRAME_OFS:   frame_r   <= {PWDATA[31:12], 12'h000};
        ASAT_DTCFG_OFS:   dtcfg_r   <= PWDATA[10:0];
        ASAT_DTOPND_OFS:  dtopnd_r  <= PWDATA;
        default:          ;
      endcase
    end
  end

  // general registers, written by software to feed the address forms
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) begin
        gpr_r[i] <= ASAT_ZERO_RST;
      end
    end else if (wr & is_gpr(PADDR)) begin
      gpr_r[PADDR[4:2]] <= PWDATA;
    end
  end

  // ****************************************************************
  // translation sequencer
  // ****************************************************************
  // one cycle for the offset, one for linear and physical
  always_comb begin
    linear_nxt = ctrl_r.real_mode
               ? ({12'h000, sel_r, 4'h0} + offset_r)
               : (segbase_r + offset_r);
    phys_nxt   = ctrl_r.paging_en
               ? {frame_r[31:ASAT_PAGE_BITS], linear_nxt[ASAT_PAGE_BITS-1:0]}
               : linear_nxt;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_r <= ASAT_IDLE;
    end else begin
      case (state_r)
        ASAT_IDLE: state_r <= go ? ASAT_ADDR : ASAT_IDLE;
        ASAT_ADDR: state_r <= (ea.range_err | ea.form_err) ? ASAT_IDLE : ASAT_XLAT;
        ASAT_XLAT: state_r <= ASAT_IDLE;
        default:   state_r <= ASAT_IDLE;
      endcase
    end
  end

  // a faulting offset never reaches the linear stage
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      offset_r   <= ASAT_ZERO_RST;
      op32_r     <= 1'b0;
      ad32_r     <= 1'b0;
      fault_r    <= 1'b0;
      form_err_r <= 1'b0;
      done_r     <= 1'b0;
      GP_FAULT   <= 1'b0;
    end else begin
      GP_FAULT <= (state_r == ASAT_ADDR) & ea.range_err;
      if (go) begin
        done_r     <= 1'b0;
        fault_r    <= 1'b0;
        form_err_r <= 1'b0;
      end else if (state_r == ASAT_ADDR) begin
        offset_r   <= ea.offset;
        op32_r     <= ea.op32;
        ad32_r     <= ea.ad32;
        fault_r    <= ea.range_err;
        form_err_r <= ea.form_err;
        done_r     <= ea.range_err | ea.form_err;
      end else if (state_r == ASAT_XLAT) begin
        done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      linear_r   <= ASAT_ZERO_RST;
      PHYS_ADDR  <= ASAT_ZERO_RST;
      PHYS_VALID <= 1'b0;
    end else begin
      PHYS_VALID <= (state_r == ASAT_XLAT);
      if (state_r == ASAT_XLAT) begin
        linear_r  <= linear_nxt;
        PHYS_ADDR <= phys_nxt;
      end
    end
  end

  // ****************************************************************
  // little-endian store window
  // ****************************************************************
  // writes 2 or 4 bytes at the physical address, low byte first;
  // the window is 16 bytes so the address wraps within it
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < ASAT_MEM_BYTES; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (store) begin
      for (int i = 0; i < 4; i++) begin
        if ((i < 2) | op32_r) begin
          mem_r[4'(PHYS_ADDR[3:0] + 4'(i))] <= PWDATA[8*i +: 8];
        end
      end
    end else if (wr & is_mem(PADDR)) begin
      for (int i = 0; i < 4; i++) begin
        mem_r[{PADDR[3:2], 2'(i)}] <= PWDATA[8*i +: 8];
      end
    end
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  // one wait state: pready rises in the second access cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= ASAT_ZERO_RST;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~is_mapped(PADDR);
      PRDATA  <= ASAT_ZERO_RST;
      if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
        if (is_mem(PADDR)) begin
          PRDATA <= {mem_r[{PADDR[3:2], 2'h3}], mem_r[{PADDR[3:2], 2'h2}],
                     mem_r[{PADDR[3:2], 2'h1}], mem_r[{PADDR[3:2], 2'h0}]};
        end else if (is_gpr(PADDR)) begin
          PRDATA <= gpr_r[PADDR[4:2]];
        end else begin
          case (PADDR)
            ASAT_CTRL_OFS:    PRDATA <= ctrl_r;
            ASAT_DISP_OFS:    PRDATA <= disp_r;
            ASAT_SEL_OFS:     PRDATA <= {16'h0000, sel_r};
            ASAT_SEGBASE_OFS: PRDATA <= segbase_r;
            ASAT_FRAME_OFS:   PRDATA <= frame_r;
            ASAT_STATUS_OFS:  PRDATA <= {23'h000000, negative, bcd_ok, bf_err, ad32_r,
                                         op32_r, form_err_r, fault_r, done_r,
                                         (state_r != ASAT_IDLE)};
            ASAT_OFFSET_OFS:  PRDATA <= offset_r;
            ASAT_LINEAR_OFS:  PRDATA <= linear_r;
            ASAT_PHYS_OFS:    PRDATA <= PHYS_ADDR;
            ASAT_DTCFG_OFS:   PRDATA <= {21'h000000, dtcfg_r};
            ASAT_DTOPND_OFS:  PRDATA <= dtopnd_r;
            ASAT_DTFIELD_OFS: PRDATA <= bf_field;
            ASAT_DTSEXT_OFS:  PRDATA <= sext;
            ASAT_PTR_OFS:     PRDATA <= {sel_r, offset_r[15:0]};
            default:          PRDATA <= ASAT_ZERO_RST;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_flag_clear_16: assert property (
    (state_r == ASAT_ADDR) & ~ctrl_r.real_mode & ~ctrl_r.def_size & ~ctrl_r.op_ovr
    |=> ~op32_r)
    else $error("flag clear did not give 16-bit operands");

  a_flag_set_32: assert property (
    (state_r == ASAT_ADDR) & ~ctrl_r.real_mode & ctrl_r.def_size & ~ctrl_r.ad_ovr
    |=> ad32_r)
    else $error("flag set did not give 32-bit addresses");

  a_real_default: assert property (
    (state_r == ASAT_ADDR) & ctrl_r.real_mode & ~ctrl_r.op_ovr & ~ctrl_r.ad_ovr
    |=> ~op32_r & ~ad32_r)
    else $error("real mode default size not 16 bits");

  a_override_inv: assert property (
    (state_r == ASAT_ADDR) & ctrl_r.real_mode & ctrl_r.op_ovr & ctrl_r.ad_ovr
    |=> op32_r & ad32_r)
    else $error("size prefixes did not invert the default");

  a_form16_check: assert property (
    (state_r == ASAT_ADDR) & ~ea.ad32 & ctrl_r.index_en & (ctrl_r.index_sel == ASAT_REG_ACC)
    |=> form_err_r ##1 (state_r == ASAT_IDLE) & ~PHYS_VALID)
    else $error("illegal 16-bit index accepted");

  a_form32_check: assert property (
    (state_r == ASAT_ADDR) & ea.ad32 & ctrl_r.index_en & (ctrl_r.index_sel == ASAT_REG_SP)
    |=> form_err_r & (state_r == ASAT_IDLE))
    else $error("stack pointer accepted as index");

  a_real_fault: assert property (
    (state_r == ASAT_ADDR) & ctrl_r.real_mode & (ea.offset > ASAT_REAL_LIMIT)
    |=> GP_FAULT & fault_r ##1 ~PHYS_VALID)
    else $error("real mode offset over limit did not fault");

  a_real_linear: assert property (
    (state_r == ASAT_XLAT) & ctrl_r.real_mode
    |=> linear_r == ({12'h000, $past(sel_r), 4'h0} + $past(offset_r)))
    else $error("real mode linear address wrong");

  a_prot_linear: assert property (
    (state_r == ASAT_XLAT) & ~ctrl_r.real_mode
    |=> linear_r == ($past(segbase_r) + $past(offset_r)))
    else $error("protected linear address wrong");

  a_paging_off: assert property (
    PHYS_VALID & ~ctrl_r.paging_en |-> PHYS_ADDR == linear_r)
    else $error("physical differs from linear with paging off");

  a_page_offset: assert property (
    PHYS_VALID |-> PHYS_ADDR[11:0] == linear_r[11:0])
    else $error("page offset bits changed by translation");

  a_store_order: assert property (
    store & op32_r
    |=> mem_r[4'($past(PHYS_ADDR[3:0]) + 4'h3)] == $past(PWDATA[31:24]))
    else $error("high byte not at highest address");

  a_trunc_16: assert property (
    (state_r == ASAT_ADDR) & ~ea.ad32 |=> offset_r[31:16] == 16'h0000)
    else $error("16-bit offset not truncated");

  c_real_xlat:  cover property ((state_r == ASAT_XLAT) & ctrl_r.real_mode ##1 PHYS_VALID);
  c_prot_paged: cover property ((state_r == ASAT_XLAT) & ctrl_r.paging_en ##1 PHYS_VALID);
  c_gp_fault:   cover property (GP_FAULT);
  c_store32:    cover property (store & op32_r);

endmodule

// >>> include/asat_pkg.sv
package asat_pkg;

  // ****************************************************************
  // register byte offsets (apb, one aligned word each, except four words at ASAT_MEM_OFS and eight at ASAT_GPR_OFS)
  // ****************************************************************
  localparam logic [11:0] ASAT_CTRL_OFS     = 12'h000;
  localparam logic [11:0] ASAT_DISP_OFS     = 12'h004;
  localparam logic [11:0] ASAT_SEL_OFS      = 12'h008;
  localparam logic [11:0] ASAT_SEGBASE_OFS  = 12'h00c;
  localparam logic [11:0] ASAT_FRAME_OFS    = 12'h010;
  localparam logic [11:0] ASAT_GO_OFS       = 12'h014;
  localparam logic [11:0] ASAT_STATUS_OFS   = 12'h018;
  localparam logic [11:0] ASAT_OFFSET_OFS   = 12'h01c;
  localparam logic [11:0] ASAT_LINEAR_OFS   = 12'h020;
  localparam logic [11:0] ASAT_PHYS_OFS     = 12'h024;
  localparam logic [11:0] ASAT_STORE_OFS    = 12'h028;
  localparam logic [11:0] ASAT_DTCFG_OFS    = 12'h02c;
  localparam logic [11:0] ASAT_DTOPND_OFS   = 12'h030;
  localparam logic [11:0] ASAT_DTFIELD_OFS  = 12'h034;
  localparam logic [11:0] ASAT_DTSEXT_OFS   = 12'h038;
  localparam logic [11:0] ASAT_PTR_OFS      = 12'h03c;
  localparam logic [11:0] ASAT_MEM_OFS      = 12'h040;
  localparam logic [11:0] ASAT_GPR_OFS      = 12'h080;

  // ****************************************************************
  // reset values, register codes and field limits
  // ****************************************************************
  localparam logic [31:0] ASAT_ZERO_RST     = 32'h0000_0000;
  localparam logic [31:0] ASAT_CTRL_RST     = 32'h0000_0002;
  localparam logic [31:0] ASAT_REAL_LIMIT   = 32'h0000_ffff;
  localparam logic [2:0]  ASAT_REG_ACC      = 3'h0;
  localparam logic [2:0]  ASAT_REG_B        = 3'h3;
  localparam logic [2:0]  ASAT_REG_SP       = 3'h4;
  localparam logic [2:0]  ASAT_REG_FRAME    = 3'h5;
  localparam logic [2:0]  ASAT_REG_SI       = 3'h6;
  localparam logic [2:0]  ASAT_REG_DEST     = 3'h7;
  localparam logic [1:0]  ASAT_DISP_NONE    = 2'h0;
  localparam logic [1:0]  ASAT_DISP_BYTE    = 2'h1;
  localparam logic [1:0]  ASAT_DISP_WIDE    = 2'h2;
  localparam logic [5:0]  ASAT_BF_MAX       = 6'h20;
  localparam logic [3:0]  ASAT_BCD_MAX      = 4'h9;
  localparam int          ASAT_MEM_BYTES    = 16;
  localparam int          ASAT_PAGE_BITS    = 12;
  localparam int          ASAT_SEL_SHIFT    = 4;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [14:0] rsvd;
    logic [2:0]  index_sel;
    logic [2:0]  base_sel;
    logic [1:0]  disp_size;
    logic [1:0]  scale;
    logic        index_en;
    logic        base_en;
    logic        ad_ovr;
    logic        op_ovr;
    logic        paging_en;
    logic        real_mode;
    logic        def_size;
  } asat_ctrl_s;

  typedef struct packed {
    logic [31:0] offset;
    logic        form_err;
    logic        range_err;
    logic        op32;
    logic        ad32;
  } asat_ea_s;

  typedef enum logic [1:0] {
    ASAT_IDLE = 2'b00,
    ASAT_ADDR = 2'b01,
    ASAT_XLAT = 2'b10
  } asat_state_e;

endpackage

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb import asat_pkg::*;;
  // ****************************************************************
  // bench state
  // ****************************************************************
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, err;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, rd, prdata, phys, o, ln, ph, d, sb, fr, msk, g[8];
  logic        prdy, pslv, pval, gpf, a32, o32, flt, fe;
  logic [15:0] s;
  logic [127:0] mm;
  asat_ctrl_s  c;
  int          n_errors = 0, compares = 0, cyc = 0, nv = 0, nf = 0, dv, df, p, l;

  asat_top dut_u (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pw),
    .PADDR(pa), .PWDATA(pwd), .PRDATA(prdata), .PREADY(prdy), .PSLVERR(pslv),
    .PHYS_ADDR(phys), .PHYS_VALID(pval), .GP_FAULT(gpf));

  // 50 ns clock; pulse counters let a test see one-cycle strobes it never polls
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (pval === 1'b1) nv++;
    if (gpf === 1'b1) nf++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge clk); psel <= 1; pw <= w; pa <= a; pwd <= v;
    @(posedge clk); pen <= 1;
    do begin @(posedge clk); end while (prdy !== 1'b1);
    rd = prdata; err = pslv; psel <= 0; pen <= 0;
  endtask
  task automatic chk(input logic [31:0] gv, input logic [31:0] ev);
    compares++;
    if (gv !== ev) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask
  // expected bit field, right aligned, for a legal position and length
  function automatic logic [31:0] fld(input logic [31:0] v, input int ps, input int ln);
    return 32'((64'(v) >> ps) & ((64'h1 << ln) - 64'h1));
  endfunction
  function automatic logic bcd(input logic [7:0] b);
    return b[3:0] <= 4'h9 && b[7:4] <= 4'h9;
  endfunction
  // start one translation and poll busy; the cycle ceiling ends a hang
  task automatic go(input asat_ctrl_s cc);
    int v0, f0;
    v0 = nv; f0 = nf;
    acc(1, ASAT_CTRL_OFS, 32'(cc)); acc(1, ASAT_GO_OFS, 0); acc(0, ASAT_STATUS_OFS, 0);
    while (rd[0] !== 1'b0) acc(0, ASAT_STATUS_OFS, 0);
    dv = nv - v0; df = nf - f0;
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h8c52));
    repeat (16) @(posedge clk);
    rst <= 0;
    acc(0, ASAT_CTRL_OFS, 0); chk(rd, ASAT_CTRL_RST);
    acc(0, 12'hffc, 0); chk(rd, 0); chk(32'(err), 1);
    $display("test regs done");
    // mode, prefix and form sweep; upper half uses full-width values to hit faults
    for (int k = 0; k < 16; k++) begin
      c = '0; c.real_mode = k[0]; c.def_size = k[1]; c.ad_ovr = k[2]; c.op_ovr = k[3];
      c.paging_en = (k[1:0] == 2'b10); c.base_en = $urandom; c.index_en = $urandom;
      c.disp_size = ASAT_DISP_WIDE; msk = k[3] ? 32'hffffffff : 32'h00003fff;
      a32 = (c.def_size & ~c.real_mode) ^ c.ad_ovr; o32 = (c.def_size & ~c.real_mode) ^ c.op_ovr;
      if (a32) begin
        c.base_sel = $urandom; c.scale = $urandom; c.index_sel = $urandom % 7;
        if (c.index_sel >= ASAT_REG_SP) c.index_sel++;
      end else begin
        c.base_sel = ($urandom % 2) ? ASAT_REG_FRAME : ASAT_REG_B;
        c.index_sel = ($urandom % 2) ? ASAT_REG_DEST : ASAT_REG_SI;
      end
      for (int r = 0; r < 8; r++) begin
        g[r] = $urandom & msk; acc(1, ASAT_GPR_OFS + 12'(r * 4), g[r]);
      end
      d = $urandom & msk; s = $urandom; sb = $urandom; fr = $urandom;
      acc(1, ASAT_DISP_OFS, d); acc(1, ASAT_SEL_OFS, {16'h0, s});
      acc(1, ASAT_SEGBASE_OFS, sb); acc(1, ASAT_FRAME_OFS, fr);
      o = (c.base_en ? g[c.base_sel] : 0) + ((c.index_en ? g[c.index_sel] : 0) << c.scale) + d;
      flt = c.real_mode & a32 & (o > ASAT_REAL_LIMIT);
      if (!a32) o[31:16] = 16'h0;
      ln = c.real_mode ? {12'h0, s, 4'h0} + o : sb + o;
      ph = c.paging_en ? {fr[31:12], ln[11:0]} : ln;
      go(c);
      chk(32'(rd[5:0]), {a32, o32, 1'b0, flt, 1'b1, 1'b0});
      chk(32'(df), 32'(flt)); chk(32'(dv), 32'(!flt));
      if (!flt) begin
        acc(0, ASAT_OFFSET_OFS, 0); chk(rd, o);
        acc(0, ASAT_LINEAR_OFS, 0); chk(rd, ln);
        chk(phys, ph);
      end
    end
    $display("test sweep done");
    // accumulator as 16-bit base and index, then stack pointer as 32-bit index
    for (int k = 0; k < 2; k++) begin
      c = '0; c.real_mode = 1; c.base_en = 1; c.base_sel = ASAT_REG_ACC;
      c.index_en = 1; c.ad_ovr = k; c.index_sel = k ? ASAT_REG_SP : ASAT_REG_ACC;
      go(c); chk(32'(rd[3]), 1); chk(32'(dv), 0);
    end
    $display("test forms done");
    // dword store lands low byte first at the translated address
    c = '0; c.def_size = 1; c.base_en = 1; c.base_sel = ASAT_REG_B; c.disp_size = ASAT_DISP_WIDE;
    go(c); ph = sb + g[ASAT_REG_B] + d; chk(phys, ph);
    for (int i = 0; i < 4; i++) acc(1, ASAT_MEM_OFS + 12'(i * 4), 0);
    d = $urandom; mm = '0;
    for (int i = 0; i < 4; i++) mm[8 * ((ph[3:0] + i) % 16) +: 8] = d[8 * i +: 8];
    acc(1, ASAT_STORE_OFS, d);
    for (int i = 0; i < 4; i++) begin
      acc(0, ASAT_MEM_OFS + 12'(i * 4), 0); chk(rd, mm[32 * i +: 32]);
    end
    $display("test store done");
    // data views: fields with corner lengths, sign in both sizes, full pointer
    o32 = 1; // the store translation ran with the 32-bit default
    for (int k = 0; k < 24; k++) begin
      d = $urandom; p = k == 0 ? 31 : k < 3 ? 0 : $urandom % 32;
      l = k == 0 ? 63 : k == 1 ? 0 : k == 2 ? 32 : 1 + $urandom % 34;
      fe = l == 0 || p + l > 32;
      if (k == 12) begin
        c = '0; c.disp_size = ASAT_DISP_WIDE; acc(1, ASAT_DISP_OFS, d); go(c); o32 = 0;
        acc(0, ASAT_PTR_OFS, 0); chk(rd, {s, d[15:0]});
      end
      acc(1, ASAT_DTOPND_OFS, d); acc(1, ASAT_DTCFG_OFS, 32'(l * 32 + p));
      acc(0, ASAT_DTFIELD_OFS, 0);
      if (!fe) chk(rd, fld(d, p, l));
      acc(0, ASAT_DTSEXT_OFS, 0); chk(rd, o32 ? d : {{16{d[15]}}, d[15:0]});
      acc(0, ASAT_STATUS_OFS, 0);
      chk(32'(rd[8:6]), {o32 ? d[31] : d[15], bcd(d[7:0]), fe});
    end
    $display("test data views done");
    tally_and_finish();
  end
endmodule
